// *** src/adc_port_regs.svh ***
// Offsets, field positions, reset values and timing counts of the port.
// Assumes inclusion by bare name from the sequencer, port and bench files.
`ifndef ADC_PORT_REGS_SVH
`define ADC_PORT_REGS_SVH

// ****************************************************************
// Bus register byte offsets
// ****************************************************************
`define OFS_CONTROL 8'h00
`define OFS_ZERO_CAL 8'h04
`define OFS_FULL_CAL 8'h08
`define OFS_RESULT 8'h0C
`define OFS_STATUS 8'h10

// ****************************************************************
// Control word fields and reset value
// ****************************************************************
`define CTRL_MODE_HI 23
`define CTRL_MODE_LO 21
`define CTRL_WORD24 20
`define CTRL_CAL_READ 19
`define CTRL_CAL_SEL 18
`define CTRL_RESET 24'h100000

// ****************************************************************
// Word lengths and calibration durations in output-rate periods
// ****************************************************************
`define LEN_SHORT 5'h10
`define LEN_LONG 5'h18
`define DUR_SELF 4'h9
`define DUR_SYS_STEP 4'h4
`define DUR_SYS_OFFSET 4'h9
`define DUR_BACKGROUND 4'h6
`define BG_RATE_DIV 3'h6

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_NS 100
`define SCLK_HALF_NS 400
`define SCLK_HALF_CYC ((`SCLK_HALF_NS + `CLK_NS - 1) / `CLK_NS)
`define OUT_RATE_NS 100000
`define OUT_RATE_CYC (`OUT_RATE_NS / `CLK_NS)

`endif

// *** src/adc_port_pkg.sv ***
// Types shared by the converter port and its calibration sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package adc_port_pkg;

   // ****************************************************************
   // Calibration mode codes held in the control word
   // ****************************************************************
   typedef enum logic [2:0] {
      CAL_NONE = 3'h0,
      CAL_SELF = 3'h1,
      CAL_SYS_ZERO = 3'h2,
      CAL_SYS_FULL = 3'h3,
      CAL_SYS_OFFSET = 3'h4,
      CAL_BACKGROUND = 3'h5
   } cal_mode_t;

   // ****************************************************************
   // Serial port states, one-hot
   // ****************************************************************
   typedef enum logic [2:0] {
      PORT_IDLE = 3'b001,
      PORT_READ = 3'b010,
      PORT_WRITE = 3'b100
   } port_state_t;

endpackage

// *** src/cal_if.sv ***
// Link between the port core and the calibration sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface cal_if;
   logic tick; // Output-rate pulse
   logic start; // Mode field written
   adc_port_pkg::cal_mode_t mode; // Mode written
   logic busy; // Calibration running
   logic done; // Calibration finished, one pulse
   logic word_ok; // A conversion word may be placed now

   modport seq (input tick, input start, input mode,
                output busy, output done, output word_ok);
   modport core (output tick, output start, output mode,
                 input busy, input done, input word_ok);
endinterface

// *** src/pulse_div.sv ***
// Free divider that gives a one-cycle enable every DIV cycles.
// Assumes a synchronous active-low reset and a same-domain clear.
`timescale 1ns/10ps
module pulse_div #(
   parameter int DIV = 4
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // Control and enable
   input wire logic i_clr,
   output logic o_tick
);
   logic [15:0] cnt_q; // Cycles since last tick

   // ****************************************************************
   // Counter; clear restarts the phase so edges line up with a frame
   // ****************************************************************
   always_ff @(posedge i_clk) begin
      if (!i_rstn || i_clr) begin
         cnt_q <= 16'h0000;
         o_tick <= 1'b0;
      end else if (cnt_q == 16'(DIV - 1)) begin
         cnt_q <= 16'h0000;
         o_tick <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 16'h0001;
         o_tick <= 1'b0;
      end
   end
endmodule

// *** src/cal_seq.sv ***
// Calibration sequencer: counts output-rate periods per mode.
// Assumes start comes one cycle wide when the mode field is written.
`timescale 1ns/10ps
`include "adc_port_regs.svh"
module cal_seq (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // Link to the core
   cal_if.seq cal
);
   logic [3:0] cnt_q; // Periods left in the running step
   logic busy_q; // Step running
   logic bg_q; // Background mode active
   logic done_q; // End-of-step pulse
   logic [2:0] bg_cnt_q; // Position in the reduced output rate

   // Periods from invocation to valid data for a mode
   function automatic logic [3:0] dur(input adc_port_pkg::cal_mode_t m);
      case (m)
         adc_port_pkg::CAL_SELF: dur = `DUR_SELF;
         adc_port_pkg::CAL_SYS_ZERO: dur = `DUR_SYS_STEP;
         adc_port_pkg::CAL_SYS_FULL: dur = `DUR_SYS_STEP;
         adc_port_pkg::CAL_SYS_OFFSET: dur = `DUR_SYS_OFFSET;
         adc_port_pkg::CAL_BACKGROUND: dur = `DUR_BACKGROUND;
         default: dur = 4'h0;
      endcase
   endfunction

   // ****************************************************************
   // Step counter; a new write restarts or cancels, except background over background
   // ****************************************************************
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         cnt_q <= 4'h0;
         busy_q <= 1'b0;
         bg_q <= 1'b0;
         done_q <= 1'b0;
      end else if (cal.start) begin
         cnt_q <= dur(cal.mode);
         busy_q <= (dur(cal.mode) != 4'h0);
         // Stays in background until the mode is rewritten
         bg_q <= (cal.mode == adc_port_pkg::CAL_BACKGROUND);
         done_q <= 1'b0;
      end else if (cal.tick && busy_q) begin
         cnt_q <= cnt_q - 4'h1;
         busy_q <= (cnt_q != 4'h1);
         done_q <= (cnt_q == 4'h1);
      end else begin
         done_q <= 1'b0;
      end
   end

   // ****************************************************************
   // Background interleave: one word in every six periods
   // ****************************************************************
   always_ff @(posedge i_clk) begin
      if (!i_rstn || cal.start) begin
         bg_cnt_q <= 3'h0;
      end else if (done_q) begin
         bg_cnt_q <= 3'h1; // First word given by the step itself
      end else if (cal.tick && bg_q && !busy_q) begin
         bg_cnt_q <= (bg_cnt_q == `BG_RATE_DIV - 3'h1) ? 3'h0
                     : bg_cnt_q + 3'h1;
      end
   end

   assign cal.busy = busy_q;
   assign cal.done = done_q;
   assign cal.word_ok = cal.tick && !busy_q && (!bg_q || bg_cnt_q == 3'h0);
endmodule

// *** src/adc_port.sv ***
// Calibration control and self-clocking serial port of the converter.
// Assumes I_CONV_WORD comes from core logic on I_CLK; all serial pins
// are asynchronous and pass two flip-flops first.
//
// Contract
// - Reset loads control word with default
// - Mode codes select the calibration kind
// - Self and offset cal: nine periods
// - System cal: two steps, four periods
// - Background cal: six periods to data
// - Mode pin high: device drives serial clock
// - Select high: output/cal; low: control
// - Ready falls on each new word
// - Ready rises after bit 16 or 24
// - Unread words keep updating, ready stays low
// - Word arriving mid-read is dropped silently
// - Control or cal reads leave ready alone
// - Frame sync with ready high: no transfer; control and cal reads run anyway
// - Frame sync fall starts clock, MSB out
// - Bits change on falling clock edges
// - Edge after LSB ends ready and drivers
// - Background stays until mode rewritten
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "adc_port_regs.svh"
module adc_port #(
   parameter int SCLK_HALF = `SCLK_HALF_CYC,
   parameter int OUT_RATE = `OUT_RATE_CYC
) (
   // Clock and reset
   input wire logic I_CLK,
   input wire logic I_RSTN,
   // APB slave
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [7:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   output logic [31:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   // Conversion word from the filter
   input wire logic [23:0] I_CONV_WORD,
   // Serial pins
   input wire logic I_MODE,
   input wire logic I_READ_FRAME_SYNC_N,
   input wire logic I_WRITE_FRAME_STROBE_N,
   input wire logic I_REGISTER_SELECT,
   input wire logic I_SDATA,
   output logic O_SDATA,
   output logic O_SDATA_OE,
   output logic O_SCLK,
   output logic O_SCLK_OE,
   output logic O_RESULT_READY_N
);
   // ****************************************************************
   // Declarations
   // ****************************************************************
   cal_if cal (); // Sequencer link
   logic [4:0] s1_q; // First synchroniser stage
   logic [4:0] s2_q; // Second synchroniser stage
   logic rfs_d1_q; // Delayed sync for edge finding
   logic tfs_d1_q; // Delayed sync for edge finding
   logic rfs_fall; // Read frame sync falling
   logic tfs_fall; // Write frame strobe falling
   logic self_clk; // Mode pin high
   logic half_tick; // Serial half-period enable
   logic rate_tick; // Output-rate enable
   adc_port_pkg::port_state_t st_q; // Serial port state
   logic [23:0] ctrl_q; // Control word
   logic [23:0] zcal_q; // Zero-scale calibration word
   logic [23:0] fcal_q; // Full-scale calibration word
   logic [23:0] out_q; // Output data word
   logic [23:0] sh_q; // Serial shift register
   logic [4:0] len_q; // Bits in this transfer
   logic [4:0] bit_q; // Rising edges so far
   logic out_rd_q; // Transfer is an output-word read
   logic wsel_q; // Select level caught for a write
   logic ser_commit; // Serial write ends now
   logic ser_end; // Any transfer ends now
   logic apb_wr; // APB write takes effect
   logic ctrl_wr; // Control word written this cycle
   logic [23:0] ctrl_new; // Value written to the control word
   adc_port_pkg::cal_mode_t new_mode; // Mode field of the new value

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   // Only the second stage is read by any logic
   always_ff @(posedge I_CLK) begin
      if (!I_RSTN) begin
         s1_q <= 5'h1F;
         s2_q <= 5'h1F;
         rfs_d1_q <= 1'b1;
         tfs_d1_q <= 1'b1;
      end else begin
         s1_q <= {I_MODE, I_READ_FRAME_SYNC_N, I_WRITE_FRAME_STROBE_N,
                  I_REGISTER_SELECT, I_SDATA};
         s2_q <= s1_q;
         rfs_d1_q <= s2_q[3];
         tfs_d1_q <= s2_q[2];
      end
   end

   assign self_clk = s2_q[4];
   assign rfs_fall = rfs_d1_q && !s2_q[3];
   assign tfs_fall = tfs_d1_q && !s2_q[2];

   // ****************************************************************
   // Dividers and sequencer
   // ****************************************************************
   // Serial divider restarts at each frame so the first edge is clean
   pulse_div #(.DIV(SCLK_HALF)) u_sclk_div (
      .i_clk(I_CLK),
      .i_rstn(I_RSTN),
      .i_clr(st_q == adc_port_pkg::PORT_IDLE),
      .o_tick(half_tick)
   );

   pulse_div #(.DIV(OUT_RATE)) u_rate_div (
      .i_clk(I_CLK),
      .i_rstn(I_RSTN),
      .i_clr(1'b0),
      .o_tick(rate_tick)
   );

   cal_seq u_cal_seq (
      .i_clk(I_CLK),
      .i_rstn(I_RSTN),
      .cal(cal)
   );

   // ****************************************************************
   // Control word write sources
   // ****************************************************************
   assign apb_wr = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE;
   assign ser_end = (st_q != adc_port_pkg::PORT_IDLE) && half_tick
                    && O_SCLK && (bit_q == len_q);
   assign ser_commit = ser_end && (st_q == adc_port_pkg::PORT_WRITE);

   // Serial write wins over a bus write in the same cycle
   always_comb begin
      ctrl_wr = 1'b0;
      ctrl_new = ctrl_q;
      if (ser_commit && !wsel_q) begin
         ctrl_wr = 1'b1;
         ctrl_new = sh_q;
      end else if (apb_wr && I_PADDR == `OFS_CONTROL) begin
         ctrl_wr = 1'b1;
         ctrl_new = I_PWDATA[23:0];
      end
   end

   assign new_mode = adc_port_pkg::cal_mode_t'(
                     ctrl_new[`CTRL_MODE_HI:`CTRL_MODE_LO]);
   assign cal.tick = rate_tick;
   assign cal.mode = new_mode;
   // Rewriting background with background must not restart it
   assign cal.start = ctrl_wr && !(new_mode == adc_port_pkg::CAL_BACKGROUND
      && ctrl_q[`CTRL_MODE_HI:`CTRL_MODE_LO] == 3'h5);

   // ****************************************************************
   // Control word
   // ****************************************************************
   always_ff @(posedge I_CLK) begin
      if (!I_RSTN) begin
         ctrl_q <= `CTRL_RESET;
      end else if (ctrl_wr) begin
         ctrl_q <= ctrl_new;
      end else if (cal.done && ctrl_q[`CTRL_MODE_HI:`CTRL_MODE_LO]
                   != 3'h5) begin
         // One-step modes fall back to plain conversion when done
         ctrl_q[`CTRL_MODE_HI:`CTRL_MODE_LO] <= 3'h0;
      end
   end

   // ****************************************************************
   // Calibration words, from bus or serial write
   // ****************************************************************
   always_ff @(posedge I_CLK) begin
      if (!I_RSTN) begin
         zcal_q <= 24'h000000;
         fcal_q <= 24'h000000;
      end else if (ser_commit && wsel_q) begin
         if (ctrl_q[`CTRL_CAL_SEL]) begin
            fcal_q <= sh_q;
         end else begin
            zcal_q <= sh_q;
         end
      end else if (apb_wr && I_PADDR == `OFS_ZERO_CAL) begin
         zcal_q <= I_PWDATA[23:0];
      end else if (apb_wr && I_PADDR == `OFS_FULL_CAL) begin
         fcal_q <= I_PWDATA[23:0];
      end
   end

   // ****************************************************************
   // Output word and ready strobe
   // ****************************************************************
   // Ready is touched only by new words, output reads and cal start
   always_ff @(posedge I_CLK) begin
      if (!I_RSTN) begin
         out_q <= 24'h000000;
         O_RESULT_READY_N <= 1'b1;
      end else if (cal.start) begin
         // Mark calibration in progress; host looks away a while
         O_RESULT_READY_N <= 1'b1;
      end else if (ser_end && out_rd_q) begin
         // Last bit gone; a word landing now is lost by design
         O_RESULT_READY_N <= 1'b1;
      end else if ((cal.done || cal.word_ok) && !out_rd_q) begin
         // Keeps updating even if unread; newest word wins
         out_q <= I_CONV_WORD;
         O_RESULT_READY_N <= 1'b0;
      end
   end

   // ****************************************************************
   // Serial port state machine
   // ****************************************************************
   always_ff @(posedge I_CLK) begin
      if (!I_RSTN) begin
         st_q <= adc_port_pkg::PORT_IDLE;
         sh_q <= 24'h000000;
         len_q <= `LEN_LONG;
         bit_q <= 5'h00;
         out_rd_q <= 1'b0;
         wsel_q <= 1'b0;
         O_SCLK <= 1'b1;
         O_SCLK_OE <= 1'b0;
         O_SDATA_OE <= 1'b0;
      end else begin
         case (st_q)
            adc_port_pkg::PORT_IDLE: begin
               bit_q <= 5'h00;
               O_SCLK <= 1'b1;
               if (self_clk && rfs_fall) begin
                  if (!s2_q[1]) begin
                     // Select low: control word, full length
                     sh_q <= ctrl_q;
                     len_q <= `LEN_LONG;
                     out_rd_q <= 1'b0;
                     st_q <= adc_port_pkg::PORT_READ;
                     O_SCLK_OE <= 1'b1;
                     O_SDATA_OE <= 1'b1;
                  end else if (ctrl_q[`CTRL_CAL_READ]) begin
                     sh_q <= ctrl_q[`CTRL_CAL_SEL] ? fcal_q : zcal_q;
                     len_q <= `LEN_LONG;
                     out_rd_q <= 1'b0;
                     st_q <= adc_port_pkg::PORT_READ;
                     O_SCLK_OE <= 1'b1;
                     O_SDATA_OE <= 1'b1;
                  end else if (!O_RESULT_READY_N) begin
                     // Output word, MSB on the line at once
                     sh_q <= out_q;
                     len_q <= ctrl_q[`CTRL_WORD24] ? `LEN_LONG
                              : `LEN_SHORT;
                     out_rd_q <= 1'b1;
                     st_q <= adc_port_pkg::PORT_READ;
                     O_SCLK_OE <= 1'b1;
                     O_SDATA_OE <= 1'b1;
                  end
                  // Ready high and output selected: nothing moves
               end else if (self_clk && tfs_fall) begin
                  wsel_q <= s2_q[1];
                  len_q <= `LEN_LONG;
                  out_rd_q <= 1'b0;
                  st_q <= adc_port_pkg::PORT_WRITE;
                  O_SCLK_OE <= 1'b1;
               end
            end
            default: begin
               if (half_tick && O_SCLK) begin
                  if (bit_q == len_q) begin
                     // Edge after the last bit shuts the drivers
                     st_q <= adc_port_pkg::PORT_IDLE;
                     O_SCLK_OE <= 1'b0;
                     O_SDATA_OE <= 1'b0;
                     out_rd_q <= 1'b0;
                  end else begin
                     O_SCLK <= 1'b0;
                     // First fall keeps the MSB that the frame put out
                     if (bit_q != 5'h00 &&
                         st_q == adc_port_pkg::PORT_READ) begin
                        sh_q <= {sh_q[22:0], 1'b0};
                     end
                  end
               end else if (half_tick) begin
                  O_SCLK <= 1'b1;
                  bit_q <= bit_q + 5'h01;
                  // Host data are sampled on our rising edge
                  if (st_q == adc_port_pkg::PORT_WRITE) begin
                     sh_q <= {sh_q[22:0], s2_q[0]};
                  end
               end
            end
         endcase
      end
   end

   assign O_SDATA = sh_q[23];

   // ****************************************************************
   // APB slave: one wait-free access phase, registered answer
   // ****************************************************************
   // Setup cycle prepares data so every answer comes from a flop
   always_ff @(posedge I_CLK) begin
      if (!I_RSTN) begin
         O_PREADY <= 1'b0;
         O_PSLVERR <= 1'b0;
         O_PRDATA <= 32'h00000000;
      end else begin
         O_PREADY <= I_PSEL && !I_PENABLE;
         O_PSLVERR <= 1'b0;
         if (I_PSEL && !I_PENABLE) begin
            if (I_PADDR == `OFS_CONTROL) begin
               O_PRDATA <= {8'h00, ctrl_q};
            end else if (I_PADDR == `OFS_ZERO_CAL) begin
               O_PRDATA <= {8'h00, zcal_q};
            end else if (I_PADDR == `OFS_FULL_CAL) begin
               O_PRDATA <= {8'h00, fcal_q};
            end else if (I_PADDR == `OFS_RESULT) begin
               O_PRDATA <= {8'h00, out_q};
            end else if (I_PADDR == `OFS_STATUS) begin
               O_PRDATA <= {27'h0000000, st_q, cal.busy,
                            O_RESULT_READY_N};
            end else begin
               // Unmapped: zero data and an error
               O_PRDATA <= 32'h00000000;
               O_PSLVERR <= 1'b1;
            end
         end
      end
   end
endmodule

// *** testbench/adc_port_monitor.sv ***
// Checker of the converter port, bound to its top module.
// Assumes a serial clock half period of four bus clock cycles.
`timescale 1ns/10ps
module adc_port_monitor (
   // Watched ports
   input wire logic I_CLK,
   input wire logic I_RSTN,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic [31:0] O_PRDATA,
   input wire logic O_PREADY,
   input wire logic O_PSLVERR,
   input wire logic I_MODE,
   input wire logic I_READ_FRAME_SYNC_N,
   input wire logic I_REGISTER_SELECT,
   input wire logic O_SDATA,
   input wire logic O_SDATA_OE,
   input wire logic O_SCLK,
   input wire logic O_SCLK_OE,
   input wire logic O_RESULT_READY_N
);
   logic sclk_q; // Serial clock one cycle ago
   logic [4:0] rises_q; // Clock rises seen in this frame
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RSTN);
   // Count rises while driving; cleared between frames
   always_ff @(posedge I_CLK) begin
      sclk_q <= O_SCLK;
      if (!I_RSTN || !O_SCLK_OE) begin
         rises_q <= 5'h00;
      end else if (O_SCLK && !sclk_q) begin
         rises_q <= rises_q + 5'h01;
      end
   end
   a_apb_one_wait: assert property (I_PSEL && !I_PENABLE |=> O_PREADY)
      else $error("no answer in first access cycle");
   a_err_no_data: assert property (O_PSLVERR |-> O_PREADY && O_PRDATA == 0)
      else $error("error without ready or with data");
   a_frame_starts: assert property ($fell(I_READ_FRAME_SYNC_N)
      && I_MODE && !O_SCLK_OE && (!I_REGISTER_SELECT || !O_RESULT_READY_N)
      |-> ##[1:6] O_SDATA_OE && O_SCLK_OE && O_SCLK)
      else $error("frame did not start the serial clock");
   a_no_transfer: assert property ($fell(I_READ_FRAME_SYNC_N)
      && I_REGISTER_SELECT && O_RESULT_READY_N && !O_SCLK_OE
      |-> (!O_SDATA_OE)[*6])
      else $error("transfer with ready high");
   a_half_period: assert property ($fell(O_SCLK) && O_SCLK_OE
      |-> (!O_SCLK)[*4] ##1 O_SCLK)
      else $error("serial clock low time wrong");
   a_bit_on_fall: assert property (O_SDATA_OE && $past(O_SDATA_OE)
      && $changed(O_SDATA) |-> $fell(O_SCLK))
      else $error("data changed off a falling clock");
   a_frame_length: assert property ($fell(O_SCLK_OE)
      |-> rises_q == 5'h10 || rises_q == 5'h18)
      else $error("frame bit count wrong");
   a_end_clock_high: assert property ($fell(O_SCLK_OE)
      |-> O_SCLK && $past(O_SCLK) && !O_SDATA_OE)
      else $error("frame end not after last high time");
   a_ready_idle: assert property ($rose(O_RESULT_READY_N)
      |-> !O_SCLK_OE)
      else $error("ready rose while still driving");
endmodule
bind adc_port adc_port_monitor i_adc_port_monitor (.*);

// *** testbench/host_port_model.sv ***
// Host serial port model, read side of the self-clocking port.
// Assumes a pull-up on the serial clock line and the port's bus clock.
`timescale 1ns/10ps
module host_port_model (
   // Clock
   input wire logic i_clk,
   // Lines from the port
   input wire logic i_sclk,
   input wire logic i_sclk_oe,
   input wire logic i_sdata,
   input wire logic i_sdata_oe,
   // Lines to the port
   output logic o_frame_n,
   output logic o_strobe_n,
   output logic o_select,
   output logic o_sdata
);
   logic last_q = 1'b0; // Last bit the port drove
   wire sclk_w = i_sclk_oe ? i_sclk : 1'b1; // Pull-up holds clock high
   wire data_w = i_sdata_oe ? i_sdata : ~last_q; // Released line drifts
   initial begin
      o_frame_n = 1'b1;
      o_strobe_n = 1'b1; // Write side unused by this model
      o_select = 1'b0;
      o_sdata = 1'b0;
   end
   // Remember the driven bit to model a floating line
   always @(posedge i_clk) begin
      if (i_sdata_oe) begin
         last_q <= i_sdata;
      end
   end
   // Read frame; ready is never looked at
   task automatic read(input logic sel, output logic [23:0] w, output int n);
      int t;
      logic sc;
      w = 24'h000000;
      n = 0;
      t = 0;
      sc = 1'b1;
      @(posedge i_clk);
      o_select <= sel; // Settled before the frame
      @(posedge i_clk);
      o_frame_n <= 1'b0;
      while (!i_sdata_oe && t < 12) begin
         @(posedge i_clk);
         t++;
      end
      // Take a bit at each clock rise until the port lets go
      while (i_sdata_oe) begin
         if (sclk_w && !sc) begin
            w = {w[22:0], data_w};
            n++;
         end
         sc = sclk_w;
         @(posedge i_clk);
      end
      o_frame_n <= 1'b1;
   endtask
endmodule

// *** testbench/adc_port_bench.sv ***
// Self-checking bench of the converter port: bus, calibration, reads.
// Assumes the host model on the serial pins and a 100 ns clock.
`timescale 1ns/10ps
`include "adc_port_regs.svh"
module adc_port_bench;
   localparam int RATE = 20; // Shortened output period keeps the run brief
   logic I_CLK = 1'b0;
   logic I_RSTN = 1'b0;
   logic I_PSEL = 1'b0;
   logic I_PENABLE = 1'b0;
   logic I_PWRITE = 1'b0;
   logic [7:0] I_PADDR = 8'h00;
   logic [31:0] I_PWDATA = 32'h00000000;
   logic [23:0] I_CONV_WORD = 24'h000000;
   logic I_MODE = 1'b1; // Self-clocking only
   logic I_READ_FRAME_SYNC_N, I_WRITE_FRAME_STROBE_N, I_REGISTER_SELECT;
   logic I_SDATA, O_PREADY, O_PSLVERR, O_SDATA, O_SDATA_OE, O_SCLK;
   logic O_SCLK_OE, O_RESULT_READY_N, er;
   logic [31:0] O_PRDATA, rd;
   logic [23:0] w;
   int n, err_total = 0, checks = 0, cycles = 0;
   initial begin
      forever #50 I_CLK = ~I_CLK;
   end
   adc_port #(.SCLK_HALF(4), .OUT_RATE(RATE)) i_adc_port (.*);
   host_port_model i_host_port_model (.i_clk(I_CLK), .i_sclk(O_SCLK),
      .i_sclk_oe(O_SCLK_OE), .i_sdata(O_SDATA), .i_sdata_oe(O_SDATA_OE),
      .o_frame_n(I_READ_FRAME_SYNC_N), .o_strobe_n(I_WRITE_FRAME_STROBE_N),
      .o_select(I_REGISTER_SELECT), .o_sdata(I_SDATA));
   // Watchdog against a hung handshake
   always @(posedge I_CLK) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         summarize();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // One bus transfer; holds everything until ready is sampled
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge I_CLK);
      I_PSEL <= 1'b1;
      I_PWRITE <= wr;
      I_PADDR <= a;
      I_PWDATA <= d;
      @(posedge I_CLK);
      I_PENABLE <= 1'b1;
      do begin
         @(posedge I_CLK);
      end while (O_PREADY !== 1'b1);
      rd = O_PRDATA;
      er = O_PSLVERR;
      I_PSEL <= 1'b0;
      I_PENABLE <= 1'b0;
   endtask
   task automatic wait_rdy;
      int t;
      t = 0;
      while (O_RESULT_READY_N !== 1'b0 && t < 400) begin
         @(posedge I_CLK);
         t++;
      end
   endtask
   task automatic t_reset;
      apb(1'b0, `OFS_CONTROL, 32'h0);
      chk(rd, {8'h00, `CTRL_RESET});
      chk(O_RESULT_READY_N, 1'b1);
      apb(1'b0, 8'h40, 32'h0);
      chk(er, 1'b1);
      chk(rd, 32'h0);
      $display("t_reset finished");
   endtask
   // Every calibration code, its duration and what follows it
   task automatic t_cal;
      logic [2:0] m [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
      int d [5] = '{9, 4, 4, 9, 6};
      int s;
      for (int i = 0; i < 5; i++) begin
         I_CONV_WORD <= 24'h5A0000 | 24'(i);
         apb(1'b1, `OFS_CONTROL, {8'h00, m[i], 1'b1, 20'h00000});
         s = cycles;
         @(posedge I_CLK); // Ready ignored just after the command
         if (i == 0) begin
            i_host_port_model.read(1'b1, w, n);
            chk(n, 0);
         end
         wait_rdy();
         chk(cycles - s > (d[i] - 1) * RATE && cycles - s <= d[i] * RATE + 4,
            1);
         i_host_port_model.read(1'b1, w, n);
         chk({n[7:0], w}, {8'h18, I_CONV_WORD});
         apb(1'b0, `OFS_CONTROL, 32'h0);
         chk(rd[23:21], m[i] == 3'h5 ? 3'h5 : 3'h0);
      end
      $display("t_cal finished");
   endtask
   // Short words, unread updates, drops mid-read, control reads
   task automatic t_words;
      I_CONV_WORD <= 24'h13579B;
      apb(1'b1, `OFS_CONTROL, 32'h00040000);
      wait_rdy();
      I_CONV_WORD <= 24'hC0FFEE;
      repeat (3 * RATE) @(posedge I_CLK);
      chk(O_RESULT_READY_N, 1'b0);
      i_host_port_model.read(1'b1, w, n);
      chk({n[7:0], w}, 32'h1000C0FF);
      chk(O_RESULT_READY_N, 1'b1);
      wait_rdy();
      apb(1'b1, `OFS_ZERO_CAL, 32'h00ABCDEF);
      apb(1'b0, `OFS_ZERO_CAL, 32'h0);
      chk(rd, 32'h00ABCDEF);
      chk(O_RESULT_READY_N, 1'b0);
      i_host_port_model.read(1'b0, w, n);
      chk({n[7:0], w}, 32'h18040000);
      chk(O_RESULT_READY_N, 1'b0);
      $display("t_words finished");
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge I_CLK);
      I_RSTN <= 1'b1;
      repeat (3) @(posedge I_CLK);
      t_reset();
      t_cal();
      t_words();
      summarize();
   end
endmodule
